// ### logic/watchdog_timer_16bit.sv
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`include "wdt_defines.svh"

module watchdog_timer_16bit
  import wdt_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  // clock, power-on reset, clock enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // reset from any other source
  input wire logic core_rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // oscillator and system conditions
  input wire logic lp_osc_i,
  input wire logic debug_halt_i,
  input wire logic periph_powerdown_i,
  // results
  output logic wd_reset_o,
  output logic timer_irq_o,
  output logic wd_locked_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [CNT_WIDTH-1:0] reload_reg;
  logic [CNT_WIDTH-1:0] count_reg;
  logic [CNT_WIDTH-1:0] count_next;
  ctrl_s ctrl_reg;
  logic lock_reg;
  logic irq_reg;
  logic wd_reset_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic osc_last_reg;

  logic osc_sync;
  logic halt_sync;
  logic osc_edge;
  logic run;
  logic tick;
  logic at_limit;
  logic expire;
  logic service_wr;
  bus_req_s req;
  reg_sel_e target;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] sel
  );
    logic [15:0] res;
    res = old_val;
    if (sel[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  function automatic reg_sel_e decode(input logic [31:0] addr);
    reg_sel_e r;
    case (addr)
      `WDT_ADDR_RELOAD: r = REG_RELOAD;
      `WDT_ADDR_COUNT: r = REG_COUNT;
      `WDT_ADDR_CONTROL: r = REG_CONTROL;
      `WDT_ADDR_SERVICE: r = REG_SERVICE;
      default: r = REG_NONE;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wdt_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .async_i({lp_osc_i, debug_halt_i}),
    .sync_o({osc_sync, halt_sync})
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_last_reg <= 1'b0;
    end else if (ce_i) begin
      osc_last_reg <= osc_sync;
    end
  end

  // rising edge of the slow oscillator, one cycle wide
  assign osc_edge = osc_sync && !osc_last_reg;

  // ---------------------------------------------------------------
  // run conditions and prescaler
  // ---------------------------------------------------------------
  // enable, debug halt and power-down (with stop_in_powerdown set) stop; all else keeps counting
  assign run = ctrl_reg.enable
    && !halt_sync
    && !(periph_powerdown_i && ctrl_reg.stop_in_powerdown);

  wdt_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .osc_edge_i(osc_edge),
    .run_i(run),
    .prescale_i(ctrl_reg.prescale),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  always_comb begin
    req.wr = cyc_i && stb_i && we_i && !ack_reg;
    req.rd = cyc_i && stb_i && !we_i && !ack_reg;
    req.sel = sel_i;
    req.data = dat_i;
  end

  assign target = decode(adr_i);
  // any write, any lanes, counts as service
  assign service_wr = req.wr && (target == REG_SERVICE);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // watchdog mode always counts down to zero
  assign at_limit = (ctrl_reg.count_up && !ctrl_reg.wd_mode) ?
    (count_reg == `WDT_COUNT_MAX) : (count_reg == `WDT_COUNT_ZERO);
  assign expire = tick && at_limit;

  always_comb begin
    count_next = count_reg;
    if (ctrl_reg.wd_mode) begin
      if (expire) begin
        count_next = reload_reg;
      end else if (tick) begin
        count_next = count_reg - 16'h0001;
      end
    end else if (expire) begin
      if (ctrl_reg.periodic) begin
        count_next = reload_reg;
      end else if (ctrl_reg.count_up) begin
        count_next = `WDT_COUNT_ZERO;
      end else begin
        count_next = `WDT_COUNT_MAX;
      end
    end else if (tick) begin
      if (ctrl_reg.count_up) begin
        count_next = count_reg + 16'h0001;
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end
  end

  // in watchdog mode, servicing wins over a tick in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= `WDT_COUNT_RST;
    end else if (ce_i) begin
      if (core_rst_i && !lock_reg) begin
        count_reg <= `WDT_COUNT_RST;
      end else if (service_wr && ctrl_reg.wd_mode) begin
        count_reg <= reload_reg;
      end else begin
        count_reg <= count_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration and lock
  // ---------------------------------------------------------------
  // lock only clears at power-on; other resets leave it alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_reg <= 1'b0;
    end else if (ce_i && ctrl_reg.wd_mode) begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_reg <= `WDT_RELOAD_RST;
    end else if (ce_i && !lock_reg) begin
      if (core_rst_i) begin
        reload_reg <= `WDT_RELOAD_RST;
      end else if (req.wr && target == REG_RELOAD) begin
        reload_reg <= merge_lanes(reload_reg, req.data, req.sel);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= ctrl_s'(`WDT_CONTROL_RST);
    end else if (ce_i && !lock_reg) begin
      if (core_rst_i) begin
        ctrl_reg <= ctrl_s'(`WDT_CONTROL_RST);
      end else if (req.wr && target == REG_CONTROL) begin
        // reserved bits never store, so they read back as zero
        ctrl_reg <= ctrl_s'(merge_lanes(ctrl_reg, req.data, req.sel)
          & `WDT_CTL_WMASK);
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt and reset request
  // ---------------------------------------------------------------
  // expiry beats a service write landing in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      if (expire && (!ctrl_reg.wd_mode || ctrl_reg.irq_en)) begin
        irq_reg <= 1'b1;
      end else if (core_rst_i && !lock_reg) begin
        irq_reg <= 1'b0;
      end else if (service_wr) begin
        irq_reg <= 1'b0;
      end
    end
  end

  // expire already implies enable, since tick needs run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_reset_reg <= 1'b0;
    end else if (ce_i) begin
      wd_reset_reg <= expire && ctrl_reg.wd_mode && ctrl_reg.enable
        && !ctrl_reg.irq_en;
    end
  end

  assign wd_reset_o = wd_reset_reg;
  assign timer_irq_o = irq_reg;
  assign wd_locked_o = lock_reg;

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  // one wait state; ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= req.wr || req.rd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else if (ce_i && req.rd) begin
      case (target)
        REG_RELOAD: rdata_reg <= {16'h0000, reload_reg};
        REG_COUNT: rdata_reg <= {16'h0000, count_reg};
        REG_CONTROL: rdata_reg <= {16'h0000, 16'(ctrl_reg)};
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;

endmodule

// ### logic/wdt_defines.svh
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define WDT_ADDR_RELOAD 32'hFFFF0360
`define WDT_ADDR_COUNT 32'hFFFF0364
`define WDT_ADDR_CONTROL 32'hFFFF0368
`define WDT_ADDR_SERVICE 32'hFFFF036C

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define WDT_RELOAD_RST 16'h0040
`define WDT_COUNT_RST 16'h0040
`define WDT_CONTROL_RST 16'h0000

// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define WDT_CTL_STOP_PD 0
`define WDT_CTL_IRQ_EN 1
`define WDT_CTL_PRE_LO 2
`define WDT_CTL_PRE_HI 3
`define WDT_CTL_WD_MODE 5
`define WDT_CTL_PERIODIC 6
`define WDT_CTL_ENABLE 7
`define WDT_CTL_COUNT_UP 8
// bits that store a value; 15..9 and 4 read as zero
`define WDT_CTL_WMASK 16'h01EF

// ---------------------------------------------------------------
// prescaler codes and division counts
// ---------------------------------------------------------------
`define WDT_PRE_DIV1 2'h0
`define WDT_PRE_DIV16 2'h1
`define WDT_PRE_DIV256 2'h2
`define WDT_PRE_RSVD 2'h3
`define WDT_DIV16_CNT 8'h0F
`define WDT_DIV256_CNT 8'hFF

// ---------------------------------------------------------------
// counter limits and oscillator rate
// ---------------------------------------------------------------
`define WDT_COUNT_MAX 16'hFFFF
`define WDT_COUNT_ZERO 16'h0000
`define WDT_OSC_HZ 32768

`endif

// ### logic/wdt_pkg.sv
package wdt_pkg;

  // control register as carried inside the block
  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic count_up;
    logic enable;
    logic periodic;
    logic wd_mode;
    logic rsvd_4;
    logic [1:0] prescale;
    logic irq_en;
    logic stop_in_powerdown;
  } ctrl_s;

  // one decoded bus access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] sel;
    logic [31:0] data;
  } bus_req_s;

  typedef enum logic [2:0] {
    REG_RELOAD,
    REG_COUNT,
    REG_CONTROL,
    REG_SERVICE,
    REG_NONE
  } reg_sel_e;

endpackage

// ### logic/wdt_sync2.sv
`timescale 1ns/1ps

module wdt_sync2 #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic clk_i,
  input wire logic ce_i,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// ### logic/wdt_prescaler.sv
`timescale 1ns/1ps
`include "wdt_defines.svh"

module wdt_prescaler
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // oscillator edge and division select
  input wire logic osc_edge_i,
  input wire logic run_i,
  input wire logic [1:0] prescale_i,
  // one cycle count tick
  output logic tick_o
);

  logic [7:0] div_reg;
  logic [7:0] limit;

  always_comb begin
    case (prescale_i)
      `WDT_PRE_DIV16: limit = `WDT_DIV16_CNT;
      `WDT_PRE_DIV256: limit = `WDT_DIV256_CNT;
      default: limit = 8'h00;
    endcase
  end

  // reserved code behaves as divide by one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 8'h00;
    end else if (ce_i && run_i && osc_edge_i) begin
      if (div_reg >= limit) begin
        div_reg <= 8'h00;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  assign tick_o = run_i && osc_edge_i && (div_reg >= limit);

endmodule

// ### sim/wdt_checker.sv
`timescale 1ns/1ps
`include "wdt_defines.svh"

module wdt_checker #(
  parameter int CNT_WIDTH = 16
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic core_rst_i,
  // register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // conditions and results
  input wire logic lp_osc_i,
  input wire logic debug_halt_i,
  input wire logic periph_powerdown_i,
  input wire logic wd_reset_o,
  input wire logic timer_irq_o,
  input wire logic wd_locked_o
);
  logic taken, svc, lock_wr;

  assign taken = cyc_i && stb_i && !ack_o && ce_i;
  assign svc = taken && we_i && adr_i == `WDT_ADDR_SERVICE;
  assign lock_wr = taken && we_i && adr_i == `WDT_ADDR_CONTROL &&
                   sel_i[0] && dat_i[5];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // halt must cross its synchroniser before counting stops
  sequence halted;
    debug_halt_i [*6];
  endsequence
  sequence lock_req;
    lock_wr ##1 ce_i;
  endsequence

  a_bus_answer: assert property (taken |=> ack_o)
    else $error("bus request not acknowledged");
  a_ack_single: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack held too long");
  a_pulse_single: assert property (wd_reset_o && ce_i |=> !wd_reset_o)
    else $error("reset request longer than one cycle");
  a_reset_locked: assert property (wd_reset_o |-> wd_locked_o)
    else $error("reset request outside watchdog mode");
  a_lock_holds: assert property (wd_locked_o |=> wd_locked_o)
    else $error("lock lost without power-on reset");
  a_lock_entry: assert property (lock_req |=> wd_locked_o)
    else $error("watchdog mode entered without lock");
  a_irq_cleared: assert property (svc |=> !timer_irq_o)
    else $error("service write left interrupt pending");
  a_irq_holds: assert property (
    timer_irq_o && !svc && !core_rst_i |=> timer_irq_o)
    else $error("interrupt dropped without service");
  a_halt_freeze: assert property (
    halted |-> !wd_reset_o && !$rose(timer_irq_o))
    else $error("timer event while core halted");
endmodule

bind watchdog_timer_16bit wdt_checker #(.CNT_WIDTH(CNT_WIDTH)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .core_rst_i(core_rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .lp_osc_i(lp_osc_i), .debug_halt_i(debug_halt_i),
  .periph_powerdown_i(periph_powerdown_i), .wd_reset_o(wd_reset_o),
  .timer_irq_o(timer_irq_o), .wd_locked_o(wd_locked_o)
);

// ### sim/testbench.sv
`timescale 1ns/1ps
`include "wdt_defines.svh"

module testbench;
  localparam logic [31:0] LD = `WDT_ADDR_RELOAD, CN = `WDT_ADDR_COUNT;
  localparam logic [31:0] CT = `WDT_ADDR_CONTROL, SV = `WDT_ADDR_SERVICE;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, core_rst_i = 1'b0;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, v, c;
  logic [3:0] sel_i = 4'hF;
  logic lp_osc_i = 1'b0, debug_halt_i = 1'b0, periph_powerdown_i = 1'b0;
  logic wd_reset_o, timer_irq_o, wd_locked_o;
  int fails = 0, checks = 0, cycles = 0, pulses = 0;

  watchdog_timer_16bit dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .core_rst_i(core_rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .lp_osc_i(lp_osc_i), .debug_halt_i(debug_halt_i),
    .periph_powerdown_i(periph_powerdown_i), .wd_reset_o(wd_reset_o),
    .timer_irq_o(timer_irq_o), .wd_locked_o(wd_locked_o)
  );

  always #5 clk_i = ~clk_i;

  // run needs some 3100 cycles; ceiling leaves ample margin
  always @(posedge clk_i) begin
    cycles++;
    if (wd_reset_o === 1'b1) pulses++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    v = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(v, e);
  endtask

  // four-cycle low phase lets the synchroniser and count settle
  task osc(input int n);
    repeat (n) begin
      lp_osc_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      lp_osc_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask

  task por();
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_regs();
    rchk(LD, 32'h40);
    rchk(CN, 32'h40);
    rchk(CT, 32'h0);
    rchk(32'hFFFF0370, 32'h0);
    wr(CN, 32'h1234);
    rchk(CN, 32'h40);
  endtask

  task t_periodic();
    wr(LD, 32'h2);
    wr(CT, 32'hC0);
    osc(64);
    rchk(CN, 32'h0);
    check(32'(timer_irq_o), 32'h0);
    osc(1);
    rchk(CN, 32'h2);
    check(32'(timer_irq_o), 32'h1);
    wr(SV, 32'h0);
    check(32'(timer_irq_o), 32'h0);
    wr(CT, 32'h80);
    osc(3);
    rchk(CN, 32'hFFFF);
  endtask

  task t_presc();
    static int div [4] = '{1, 16, 256, 1};
    for (int i = 0; i < 4; i++) begin
      wr(CT, 32'h80 | 32'(i << 2));
      bus(1'b0, CN, 32'h0);
      c = v;
      if (div[i] > 1) begin
        osc(div[i] - 1);
        rchk(CN, c);
      end
      osc(1);
      rchk(CN, {16'h0, c[15:0] - 16'h1});
    end
  endtask

  task t_dir();
    wr(CT, 32'h180);
    bus(1'b0, CN, 32'h0);
    c = v;
    osc(2);
    rchk(CN, {16'h0, c[15:0] + 16'h2});
    wr(CT, 32'h100);
    osc(2);
    rchk(CN, {16'h0, c[15:0] + 16'h2});
  endtask

  task t_hold();
    wr(CT, 32'h80);
    bus(1'b0, CN, 32'h0);
    c = v;
    debug_halt_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    osc(3);
    rchk(CN, c);
    debug_halt_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    periph_powerdown_i <= 1'b1;
    osc(1);
    rchk(CN, {16'h0, c[15:0] - 16'h1});
    wr(CT, 32'h81);
    osc(1);
    rchk(CN, {16'h0, c[15:0] - 16'h1});
    periph_powerdown_i <= 1'b0;
    osc(1);
    rchk(CN, {16'h0, c[15:0] - 16'h2});
    // clock enable low: oscillator edges must leave the count alone
    ce_i <= 1'b0;
    osc(2);
    ce_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk(CN, {16'h0, c[15:0] - 16'h2});
  endtask

  task t_wd_irq();
    // short timeout keeps the run brief; real software stays >= 30 ms
    wr(LD, 32'h3);
    wr(CT, 32'hA2);
    wr(SV, 32'h0);
    check(32'(wd_locked_o), 32'h1);
    wr(LD, 32'h9);
    wr(CT, 32'h0);
    rchk(LD, 32'h3);
    rchk(CT, 32'hA2);
    osc(2);
    rchk(CN, 32'h1);
    wr(SV, 32'h0);
    rchk(CN, 32'h3);
    osc(4);
    rchk(CN, 32'h3);
    check(32'(timer_irq_o), 32'h1);
    check(32'(pulses), 32'h0);
  endtask

  task t_wd_rst();
    por();
    rchk(CT, 32'h0);
    // unlocked: other resets restore the defaults
    wr(LD, 32'h5);
    core_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    core_rst_i <= 1'b0;
    rchk(LD, 32'h40);
    wr(LD, 32'h2);
    wr(CT, 32'hA0);
    wr(SV, 32'h0);
    core_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    core_rst_i <= 1'b0;
    rchk(CT, 32'hA0);
    rchk(CN, 32'h2);
    osc(3);
    check(32'(pulses), 32'h1);
    check(32'(timer_irq_o), 32'h0);
    osc(3);
    check(32'(pulses), 32'h2);
  endtask

  initial begin
    por();
    t_regs();
    t_periodic();
    t_presc();
    t_dir();
    t_hold();
    t_wd_irq();
    t_wd_rst();
    results();
  end
endmodule
